// ===== pkg/pmblf_pkg.sv
package pmblf_pkg;
  // command codes
  localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20;
  localparam logic [7:0] CMD_VOUT_SET = 8'h21;
  localparam logic [7:0] CMD_CAL_OFFSET = 8'h23;
  localparam logic [7:0] CMD_MARGIN_HI = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LO = 8'h26;
  localparam logic [7:0] CMD_DROOP = 8'h28;
  localparam logic [7:0] CMD_INPUT_TURN_ON_LEVEL = 8'h35;
  localparam logic [7:0] CMD_INPUT_TURN_OFF_LEVEL = 8'h36;
  localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
  localparam logic [7:0] CMD_OV_ACTION = 8'h41;
  localparam logic [7:0] CMD_OC_LIMIT = 8'h46;
  localparam logic [7:0] CMD_OC_ACTION = 8'h47;
  localparam logic [7:0] CMD_OC_WARN = 8'h4a;
  localparam logic [7:0] CMD_OT_LIMIT = 8'h4f;
  localparam logic [7:0] CMD_OT_ACTION = 8'h50;

  // output format byte: linear mode, exponent -12
  localparam logic [7:0] VOUT_FORMAT_VAL = 8'h14;

  // action byte fields
  localparam int ACT_RSP_LSB = 6;
  localparam int ACT_RETRY_LSB = 3;
  localparam logic [1:0] RSP_OV = 2'h2;
  localparam logic [1:0] RSP_OC = 2'h3;
  localparam logic [1:0] RSP_OT = 2'h2;
  localparam logic [2:0] DELAY_NONE = 3'h0;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_CONT = 3'h7;

  // output voltage codes, lsb = 2^-12 V
  localparam logic [15:0] VOUT_MIN = 16'h5000;     // 5.000 V
  localparam logic [15:0] VOUT_MAX = 16'hd333;     // 13.200 V
  localparam logic [15:0] OV_MIN = 16'hae67;       // 10.90 V
  localparam logic [15:0] OV_MAX = 16'hffd7;       // 15.99 V
  localparam logic [16:0] OV_HEADROOM = 17'h03fd7; // 3.99 V
  localparam logic signed [15:0] CAL_MAX = 16'sh0400;  // +0.25 V
  localparam logic signed [15:0] CAL_MIN = -16'sh0400; // -0.25 V
  // droop, lsb = 0.1 mV/A
  localparam logic [15:0] DROOP_MAX = 16'h01f4;    // 50
  localparam logic [15:0] DROOP_PAR = 16'h008f;    // 14.3
  // input volts, amps and degrees, lsb = 1/16
  localparam logic [15:0] VIN_MIN = 16'h0210;      // 33 V
  localparam logic [15:0] VIN_MAX = 16'h02e0;      // 46 V
  localparam logic [15:0] VIN_HYST = 16'h0020;     // 2 V
  localparam logic [15:0] OC_MIN = 16'h00f0;       // 15 A
  localparam logic [15:0] OC_MAX = 16'h03c0;       // 60 A
  localparam logic [15:0] OCW_MIN = 16'h0080;      // 8 A
  localparam logic [15:0] OCW_MAX = 16'h0320;      // 50 A
  localparam logic [15:0] OT_MIN = 16'h0190;       // 25 C
  localparam logic [15:0] OT_MAX = 16'h08c0;       // 140 C

  // reset values
  localparam logic [15:0] VOUT_SET_RST = 16'hc000;  // 12.000 V
  localparam logic [15:0] CAL_RST = 16'h0000;
  localparam logic [15:0] MARGIN_HI_RST = 16'hc99a;
  localparam logic [15:0] MARGIN_LO_RST = 16'hb666;
  localparam logic [15:0] INPUT_TURN_ON_LEVEL_RST = 16'h0230;
  localparam logic [15:0] INPUT_TURN_OFF_LEVEL_RST = 16'h0210;
  localparam logic [15:0] OV_LIMIT_RST = 16'he000;
  localparam logic [15:0] OC_LIMIT_RST = 16'h0320;
  localparam logic [15:0] OC_WARN_RST = 16'h0280;
  localparam logic [15:0] OT_LIMIT_RST = 16'h07d0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] data;
  } pmblf_cmd_t;

  typedef struct packed {
    logic ack;
    logic bad_cmd;
    logic bad_data;
    logic [15:0] data;
  } pmblf_rsp_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_LATCH = 3'b010,
    ST_RETRY = 3'b100
  } pmblf_state_t;
endpackage

// ===== src/pmblf_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] format byte read-only, linear, exponent -12
// [RULE_02] setpoint 16-bit mantissa, resets to 12 V
// [RULE_03] setpoint accepted only 5.000 to 13.200 V
// [RULE_04] offset within 0.25 V, lockable by type
// [RULE_05] margins 5.0-13.2 V, low below high
// [RULE_06] droop 0-50 mV/A, default 0 or 14.3
// [RULE_07] input thresholds 33-46 V, 2 V hysteresis
// [RULE_08] overvoltage limit 10.90-15.99 V, above setpoint
// [RULE_09] hidden ceiling setpoint plus 3.99, max 15.99
// [RULE_10] overvoltage response fixed 10, retry writable
// [RULE_11] only retry 000 or 111 allowed
// [RULE_12] delay field always zero, read-only
// [RULE_13] overcurrent response fixed 11, continuous restart; the code also accepts retry 000 on write and then latches off
// [RULE_14] overcurrent limit 15-60 A, above warning
// [RULE_15] warning 8-50 A, below fault limit
// [RULE_16] overtemperature limit 25-140 C, above warning
// [RULE_17] overtemperature response fixed 10, continuous restart; the code also accepts retry 000 on write and then latches off
// [RULE_18] action bytes reset with retry 111, delay 000
// [RULE_19] bad writes rejected, value kept, flagged
// [RULE_20] host orders related writes to pass checks
module pmblf_regs #(
  parameter bit PARALLEL_UNIT = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // command port
  input wire pmblf_pkg::pmblf_cmd_t cmd,
  output pmblf_pkg::pmblf_rsp_t rsp,
  // neighbouring state
  input wire logic cal_lock,
  input wire logic [15:0] ot_warn_level,
  input wire logic on_request,
  // fault pins, bit 0 ov, 1 oc, 2 ot
  input wire logic [2:0] fault_pin,
  // settings to the power stage
  output logic [15:0] vout_target,
  output logic [15:0] ov_trip_level,
  output logic [15:0] droop_slope,
  output logic [15:0] input_turn_on_level_level,
  output logic [15:0] input_turn_off_level_level,
  output logic [15:0] oc_trip_level,
  output logic [15:0] oc_warn_level,
  output logic [15:0] ot_trip_level,
  output logic shutdown,
  output logic restart
);

  typedef struct packed {
    logic [15:0] vout_set;
    logic [15:0] cal_off;
    logic [15:0] marg_hi;
    logic [15:0] marg_lo;
    logic [15:0] droop;
    logic [15:0] input_turn_on_level;
    logic [15:0] input_turn_off_level;
    logic [15:0] ov_lim;
    logic [15:0] oc_lim;
    logic [15:0] oc_warn;
    logic [15:0] ot_lim;
    logic [2:0] ov_retry;
    logic [2:0] oc_retry;
    logic [2:0] ot_retry;
    logic [15:0] ov_ceil;
    logic [2:0] flt_s1;
    logic [2:0] flt_s2;
    pmblf_pkg::pmblf_state_t st;
    logic shutdown;
    logic restart;
    pmblf_pkg::pmblf_rsp_t rsp;
  } pmblf_regs_t;

  localparam pmblf_regs_t RST = '{
    vout_set: pmblf_pkg::VOUT_SET_RST, // see [RULE_02]
    cal_off: pmblf_pkg::CAL_RST,
    marg_hi: pmblf_pkg::MARGIN_HI_RST,
    marg_lo: pmblf_pkg::MARGIN_LO_RST,
    droop: PARALLEL_UNIT ? pmblf_pkg::DROOP_PAR : 16'h0000, // see [RULE_06]
    input_turn_on_level: pmblf_pkg::INPUT_TURN_ON_LEVEL_RST,
    input_turn_off_level: pmblf_pkg::INPUT_TURN_OFF_LEVEL_RST,
    ov_lim: pmblf_pkg::OV_LIMIT_RST,
    oc_lim: pmblf_pkg::OC_LIMIT_RST,
    oc_warn: pmblf_pkg::OC_WARN_RST,
    ot_lim: pmblf_pkg::OT_LIMIT_RST,
    ov_retry: pmblf_pkg::RETRY_CONT, // see [RULE_18]
    oc_retry: pmblf_pkg::RETRY_CONT, // see [RULE_13]
    ot_retry: pmblf_pkg::RETRY_CONT, // see [RULE_17]
    ov_ceil: pmblf_pkg::OV_LIMIT_RST,
    flt_s1: 3'h0,
    flt_s2: 3'h0,
    st: pmblf_pkg::ST_RUN,
    shutdown: 1'b0,
    restart: 1'b0,
    rsp: '0
  };

  pmblf_regs_t s_q;
  pmblf_regs_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [7:0] action_byte(input logic [1:0] rsp_f,
                                             input logic [2:0] retry);
    action_byte = {rsp_f, retry, pmblf_pkg::DELAY_NONE}; // see [RULE_12]
  endfunction

  function automatic logic retry_ok(input logic [2:0] r);
    retry_ok = (r == pmblf_pkg::RETRY_NONE) || (r == pmblf_pkg::RETRY_CONT); // see [RULE_11]
  endfunction

  logic [16:0] ceil_sum;
  logic [15:0] ceil_cap;
  logic [2:0] flt;
  logic [2:0] latch_sel;
  logic [2:0] wr_retry;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    s_d.rsp = '0;
    wr_retry = cmd.data[pmblf_pkg::ACT_RETRY_LSB +: 3];

    // fault pins cross in through two flops
    s_d.flt_s1 = fault_pin;
    s_d.flt_s2 = s_q.flt_s1;

    // hidden ceiling, never readable
    ceil_sum = {1'b0, s_q.vout_set} + pmblf_pkg::OV_HEADROOM;
    ceil_cap = (ceil_sum > {1'b0, pmblf_pkg::OV_MAX}) ? pmblf_pkg::OV_MAX : ceil_sum[15:0];
    s_d.ov_ceil = (s_q.ov_lim < ceil_cap) ? s_q.ov_lim : ceil_cap; // see [RULE_09]

    if (cmd.wr) begin
      s_d.rsp.ack = 1'b1;
      if (cmd.code == pmblf_pkg::CMD_VOUT_FORMAT) begin
        s_d.rsp.bad_cmd = 1'b1; // see [RULE_01]
      end else if (cmd.code == pmblf_pkg::CMD_VOUT_SET) begin
        if (in_range(cmd.data, pmblf_pkg::VOUT_MIN, pmblf_pkg::VOUT_MAX)) begin // see [RULE_03]
          s_d.vout_set = cmd.data;
        end else begin
          s_d.rsp.bad_data = 1'b1; // see [RULE_19]
        end
      end else if (cmd.code == pmblf_pkg::CMD_CAL_OFFSET) begin
        if (!cal_lock && ($signed(cmd.data) <= pmblf_pkg::CAL_MAX)
            && ($signed(cmd.data) >= pmblf_pkg::CAL_MIN)) begin // see [RULE_04]
          s_d.cal_off = cmd.data;
        end else begin
          s_d.rsp.bad_data = 1'b1;
        end
      end else if (cmd.code == pmblf_pkg::CMD_MARGIN_HI) begin
        if (in_range(cmd.data, pmblf_pkg::VOUT_MIN, pmblf_pkg::VOUT_MAX)
            && cmd.data > s_q.marg_lo) begin // see [RULE_05]
          s_d.marg_hi = cmd.data;
        end else begin
          s_d.rsp.bad_data = 1'b1;
        end
      end else if (cmd.code == pmblf_pkg::CMD_MARGIN_LO) begin
        if (in_range(cmd.data, pmblf_pkg::VOUT_MIN, pmblf_pkg::VOUT_MAX)
            && cmd.data < s_q.marg_hi) begin // see [RULE_05]
          s_d.marg_lo = cmd.data;
        end else begin
          s_d.rsp.bad_data = 1'b1;
        end
      end else if (cmd.code == pmblf_pkg::CMD_DROOP) begin
        if (cmd.data <= pmblf_pkg::DROOP_MAX) begin // see [RULE_06]
          s_d.droop = cmd.data;
        end else begin
          s_d.rsp.bad_data = 1'b1;
        end
      end else if (cmd.code == pmblf_pkg::CMD_INPUT_TURN_ON_LEVEL) begin
        // on must sit at least the gap above off
        if (in_range(cmd.data, pmblf_pkg::VIN_MIN, pmblf_pkg::VIN_MAX)
            && ({1'b0, cmd.data} >= {1'b0, s_q.input_turn_off_level} + {1'b0, pmblf_pkg::VIN_HYST})) begin // see [RULE_07]
          s_d.input_turn_on_level = cmd.data;
        end else begin
          s_d.rsp.bad_data = 1'b1;
        end
      end else if (cmd.code == pmblf_pkg::CMD_INPUT_TURN_OFF_LEVEL) begin
        if (in_range(cmd.data, pmblf_pkg::VIN_MIN, pmblf_pkg::VIN_MAX)
            && ({1'b0, cmd.data} + {1'b0, pmblf_pkg::VIN_HYST} <= {1'b0, s_q.input_turn_on_level})) begin // see [RULE_07]
          s_d.input_turn_off_level = cmd.data;
        end else begin
          s_d.rsp.bad_data = 1'b1;
        end
      end else if (cmd.code == pmblf_pkg::CMD_OV_LIMIT) begin
        if (in_range(cmd.data, pmblf_pkg::OV_MIN, pmblf_pkg::OV_MAX)
            && cmd.data > s_q.vout_set) begin // see [RULE_08]
          s_d.ov_lim = cmd.data;
        end else begin
          s_d.rsp.bad_data = 1'b1;
        end
      end else if (cmd.code == pmblf_pkg::CMD_OV_ACTION) begin
        // response and delay bits are read-only and ignored on write
        if (retry_ok(wr_retry)) begin // see [RULE_10]
          s_d.ov_retry = wr_retry;
        end else begin
          s_d.rsp.bad_data = 1'b1;
        end
      end else if (cmd.code == pmblf_pkg::CMD_OC_LIMIT) begin
        if (in_range(cmd.data, pmblf_pkg::OC_MIN, pmblf_pkg::OC_MAX)
            && cmd.data > s_q.oc_warn) begin // see [RULE_14]
          s_d.oc_lim = cmd.data;
        end else begin
          s_d.rsp.bad_data = 1'b1;
        end
      end else if (cmd.code == pmblf_pkg::CMD_OC_ACTION) begin
        if (retry_ok(wr_retry)) begin // see [RULE_13]
          s_d.oc_retry = wr_retry;
        end else begin
          s_d.rsp.bad_data = 1'b1;
        end
      end else if (cmd.code == pmblf_pkg::CMD_OC_WARN) begin
        if (in_range(cmd.data, pmblf_pkg::OCW_MIN, pmblf_pkg::OCW_MAX)
            && cmd.data < s_q.oc_lim) begin // see [RULE_15]
          s_d.oc_warn = cmd.data;
        end else begin
          s_d.rsp.bad_data = 1'b1;
        end
      end else if (cmd.code == pmblf_pkg::CMD_OT_LIMIT) begin
        if (in_range(cmd.data, pmblf_pkg::OT_MIN, pmblf_pkg::OT_MAX)
            && cmd.data > ot_warn_level) begin // see [RULE_16]
          s_d.ot_lim = cmd.data;
        end else begin
          s_d.rsp.bad_data = 1'b1;
        end
      end else if (cmd.code == pmblf_pkg::CMD_OT_ACTION) begin
        if (retry_ok(wr_retry)) begin // see [RULE_17]
          s_d.ot_retry = wr_retry;
        end else begin
          s_d.rsp.bad_data = 1'b1;
        end
      end else begin
        s_d.rsp.bad_cmd = 1'b1;
      end
    end else if (cmd.rd) begin
      s_d.rsp.ack = 1'b1;
      if (cmd.code == pmblf_pkg::CMD_VOUT_FORMAT) begin
        s_d.rsp.data = {8'h00, pmblf_pkg::VOUT_FORMAT_VAL}; // see [RULE_01]
      end else if (cmd.code == pmblf_pkg::CMD_VOUT_SET) begin
        s_d.rsp.data = s_q.vout_set;
      end else if (cmd.code == pmblf_pkg::CMD_CAL_OFFSET) begin
        s_d.rsp.data = s_q.cal_off;
      end else if (cmd.code == pmblf_pkg::CMD_MARGIN_HI) begin
        s_d.rsp.data = s_q.marg_hi;
      end else if (cmd.code == pmblf_pkg::CMD_MARGIN_LO) begin
        s_d.rsp.data = s_q.marg_lo;
      end else if (cmd.code == pmblf_pkg::CMD_DROOP) begin
        s_d.rsp.data = s_q.droop;
      end else if (cmd.code == pmblf_pkg::CMD_INPUT_TURN_ON_LEVEL) begin
        s_d.rsp.data = s_q.input_turn_on_level;
      end else if (cmd.code == pmblf_pkg::CMD_INPUT_TURN_OFF_LEVEL) begin
        s_d.rsp.data = s_q.input_turn_off_level;
      end else if (cmd.code == pmblf_pkg::CMD_OV_LIMIT) begin
        s_d.rsp.data = s_q.ov_lim; // user value, never the ceiling
      end else if (cmd.code == pmblf_pkg::CMD_OV_ACTION) begin
        s_d.rsp.data = {8'h00, action_byte(pmblf_pkg::RSP_OV, s_q.ov_retry)}; // see [RULE_10]
      end else if (cmd.code == pmblf_pkg::CMD_OC_LIMIT) begin
        s_d.rsp.data = s_q.oc_lim;
      end else if (cmd.code == pmblf_pkg::CMD_OC_ACTION) begin
        s_d.rsp.data = {8'h00, action_byte(pmblf_pkg::RSP_OC, s_q.oc_retry)}; // see [RULE_13]
      end else if (cmd.code == pmblf_pkg::CMD_OC_WARN) begin
        s_d.rsp.data = s_q.oc_warn;
      end else if (cmd.code == pmblf_pkg::CMD_OT_LIMIT) begin
        s_d.rsp.data = s_q.ot_lim;
      end else if (cmd.code == pmblf_pkg::CMD_OT_ACTION) begin
        s_d.rsp.data = {8'h00, action_byte(pmblf_pkg::RSP_OT, s_q.ot_retry)}; // see [RULE_17]
      end else begin
        s_d.rsp.bad_cmd = 1'b1;
      end
    end

    // fault reaction: a fault with retry 000 latches off, 111 keeps retrying
    flt = s_q.flt_s2;
    latch_sel = flt & {s_q.ot_retry == pmblf_pkg::RETRY_NONE,
                       s_q.oc_retry == pmblf_pkg::RETRY_NONE,
                       s_q.ov_retry == pmblf_pkg::RETRY_NONE};
    if (!on_request) begin
      s_d.st = pmblf_pkg::ST_RUN; // commanded off ends retry and latch
    end else begin
      case (s_q.st)
        pmblf_pkg::ST_RUN: begin
          if (|latch_sel) begin
            s_d.st = pmblf_pkg::ST_LATCH;
          end else if (|flt) begin
            s_d.st = pmblf_pkg::ST_RETRY;
          end
        end
        pmblf_pkg::ST_RETRY: begin
          // another fault without retry latches it off until commanded off
          if (|latch_sel) begin // see [RULE_11]
            s_d.st = pmblf_pkg::ST_LATCH;
          end else if (!(|flt)) begin
            s_d.st = pmblf_pkg::ST_RUN;
          end
        end
        pmblf_pkg::ST_LATCH: begin
          s_d.st = pmblf_pkg::ST_LATCH;
        end
        default: begin
          s_d.st = pmblf_pkg::ST_RUN;
        end
      endcase
    end
    s_d.shutdown = !on_request || (s_d.st != pmblf_pkg::ST_RUN);
    s_d.restart = on_request && (s_d.st == pmblf_pkg::ST_RETRY); // see [RULE_11]
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  assign rsp = s_q.rsp;
  assign vout_target = s_q.vout_set;
  assign ov_trip_level = s_q.ov_ceil;
  assign droop_slope = s_q.droop;
  assign input_turn_on_level_level = s_q.input_turn_on_level;
  assign input_turn_off_level_level = s_q.input_turn_off_level;
  assign oc_trip_level = s_q.oc_lim;
  assign oc_warn_level = s_q.oc_warn;
  assign ot_trip_level = s_q.ot_lim;
  assign shutdown = s_q.shutdown;
  assign restart = s_q.restart;

endmodule

// ===== dv/pmblf_regs_monitor.sv
`timescale 1ns/1ps
module pmblf_regs_chk #(
  parameter bit PARALLEL_UNIT = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // command port
  input wire pmblf_pkg::pmblf_cmd_t cmd,
  input wire pmblf_pkg::pmblf_rsp_t rsp,
  // settings out
  input wire logic [15:0] vout_target,
  input wire logic [15:0] ov_trip_level,
  input wire logic [15:0] input_turn_on_level_level,
  input wire logic [15:0] input_turn_off_level_level,
  input wire logic [15:0] oc_trip_level,
  input wire logic [15:0] oc_warn_level,
  input wire logic shutdown,
  input wire logic restart
);
  logic [16:0] ceil_sum;
  logic [15:0] ceil_q;
  logic rd_only;
  logic act_wr;

  assign ceil_sum = {1'b0, vout_target} + pmblf_pkg::OV_HEADROOM;
  assign rd_only = cmd.rd && !cmd.wr;
  assign act_wr = cmd.wr && (cmd.code inside {8'h41, 8'h47, 8'h50});

  // ceiling lags setpoint by one cycle, same as the trip level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ceil_q <= pmblf_pkg::OV_MAX;
    end else begin
      ceil_q <= (ceil_sum > {1'b0, pmblf_pkg::OV_MAX}) ? pmblf_pkg::OV_MAX : ceil_sum[15:0];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_act(logic [7:0] c, logic [1:0] r);
    (rd_only && cmd.code == c) |=>
      rsp.data[7:6] == r && rsp.data[2:0] == pmblf_pkg::DELAY_NONE;
  endproperty

  a_ack_after_req:
    assert property ((cmd.wr || cmd.rd) |=> rsp.ack) else $error("ack missing");
  a_format_value:
    assert property ((rd_only && cmd.code == pmblf_pkg::CMD_VOUT_FORMAT) |=>
      rsp.data == {8'h00, pmblf_pkg::VOUT_FORMAT_VAL}) else $error("format byte wrong");
  a_format_ro:
    assert property ((cmd.wr && cmd.code == pmblf_pkg::CMD_VOUT_FORMAT) |=> rsp.bad_cmd)
    else $error("format write not refused");
  a_vout_reject:
    assert property ((cmd.wr && cmd.code == pmblf_pkg::CMD_VOUT_SET &&
      (cmd.data < pmblf_pkg::VOUT_MIN || cmd.data > pmblf_pkg::VOUT_MAX)) |=>
      rsp.bad_data && $stable(vout_target)) else $error("bad setpoint taken");
  a_ov_ceiling:
    assert property (ov_trip_level <= ceil_q) else $error("trip above ceiling");
  a_ov_action:
    assert property (p_act(8'h41, pmblf_pkg::RSP_OV)) else $error("ov action fields");
  a_oc_action:
    assert property (p_act(8'h47, pmblf_pkg::RSP_OC)) else $error("oc action fields");
  a_ot_action:
    assert property (p_act(8'h50, pmblf_pkg::RSP_OT)) else $error("ot action fields");
  a_retry_legal:
    assert property ((act_wr && !(cmd.data[5:3] inside {3'h0, 3'h7})) |=> rsp.bad_data)
    else $error("bad retry taken");
  a_vin_gap:
    assert property (input_turn_on_level_level >= input_turn_off_level_level + pmblf_pkg::VIN_HYST)
    else $error("input gap lost");
  a_oc_order:
    assert property (oc_warn_level < oc_trip_level) else $error("warn not below limit");
  a_retry_off:
    assert property (restart |-> shutdown) else $error("restart while running");

  c_bad_data: cover property (rsp.ack && rsp.bad_data);
  c_restart: cover property ($rose(restart));
  c_latch: cover property (shutdown && !restart);
endmodule

bind pmblf_regs pmblf_regs_chk #(.PARALLEL_UNIT(PARALLEL_UNIT)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp), .vout_target(vout_target),
  .ov_trip_level(ov_trip_level), .input_turn_on_level_level(input_turn_on_level_level),
  .input_turn_off_level_level(input_turn_off_level_level), .oc_trip_level(oc_trip_level),
  .oc_warn_level(oc_warn_level), .shutdown(shutdown), .restart(restart));

// ===== dv/pmblf_host.sv
`timescale 1ns/1ps
module pmblf_host (
  // clock
  input wire logic ref_clk,
  // command port toward the device
  output pmblf_pkg::pmblf_cmd_t cmd,
  input wire pmblf_pkg::pmblf_rsp_t rsp
);
  initial cmd = '0;

  // one command at a time, so dependent writes land in the caller's order
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output pmblf_pkg::pmblf_rsp_t r);
    @(negedge ref_clk);
    cmd = {wr, ~wr, code, data};
    @(negedge ref_clk);
    r = rsp;
    // released data shows garbage, not the last word
    cmd = {1'b0, 1'b0, ~code, ~data};
  endtask
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic ref_clk;
  logic rst_n;
  pmblf_pkg::pmblf_cmd_t cmd;
  pmblf_pkg::pmblf_rsp_t rsp;
  pmblf_pkg::pmblf_rsp_t r;
  logic cal_lock;
  logic on_request;
  logic [2:0] fault_pin;
  logic [15:0] ot_warn_level;
  logic [15:0] vout_target;
  logic [15:0] ov_trip_level;
  logic [15:0] oc_trip_level;
  logic [15:0] oc_warn_level;
  logic [15:0] droop_slope;
  logic [15:0] input_turn_on_level_level;
  logic [15:0] input_turn_off_level_level;
  logic [15:0] ot_trip_level;
  logic shutdown;
  logic restart;
  logic [15:0] shadow [256];
  logic [7:0] c;
  logic [15:0] d;
  logic b;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [23:0] rst_tab [15] = '{
    {8'h20, 16'h0014}, {8'h21, 16'hc000}, {8'h23, 16'h0000}, {8'h25, 16'hc99a},
    {8'h26, 16'hb666}, {8'h28, 16'h0000}, {8'h35, 16'h0230}, {8'h36, 16'h0210},
    {8'h40, 16'he000}, {8'h41, 16'h00b8}, {8'h46, 16'h0320}, {8'h47, 16'h00f8},
    {8'h4a, 16'h0280}, {8'h4f, 16'h07d0}, {8'h50, 16'h00b8}};
  // ordered so every accepted write keeps the cross-checks true
  logic [24:0] steps [] = '{
    {8'h21, 16'h4fff, 1'b1}, {8'h21, 16'hd334, 1'b1}, {8'h21, 16'h5000, 1'b0},
    {8'h21, 16'hd333, 1'b0}, {8'h23, 16'h0401, 1'b1}, {8'h23, 16'hfc00, 1'b0},
    {8'h23, 16'hfbff, 1'b1}, {8'h25, 16'hb666, 1'b1}, {8'h26, 16'h4fff, 1'b1},
    {8'h26, 16'hc99a, 1'b1}, {8'h25, 16'hd334, 1'b1}, {8'h26, 16'h5000, 1'b0},
    {8'h25, 16'hd333, 1'b0}, {8'h28, 16'h01f5, 1'b1}, {8'h28, 16'h01f4, 1'b0},
    {8'h36, 16'h0211, 1'b1}, {8'h35, 16'h02e1, 1'b1}, {8'h35, 16'h02e0, 1'b0},
    {8'h36, 16'h02c1, 1'b1}, {8'h36, 16'h02c0, 1'b0}, {8'h36, 16'h020f, 1'b1},
    {8'h35, 16'h02df, 1'b1}, {8'h40, 16'hd333, 1'b1}, {8'h40, 16'hae66, 1'b1},
    {8'h40, 16'hffd8, 1'b1}, {8'h40, 16'hffd7, 1'b0}, {8'h4a, 16'h0320, 1'b1},
    {8'h4a, 16'h031f, 1'b0}, {8'h46, 16'h031f, 1'b1}, {8'h46, 16'h03c1, 1'b1},
    {8'h46, 16'h03c0, 1'b0}, {8'h4a, 16'h0321, 1'b1}, {8'h4a, 16'h007f, 1'b1},
    {8'h4f, 16'h0640, 1'b1}, {8'h4f, 16'h08c1, 1'b1}, {8'h4f, 16'h08c0, 1'b0},
    {8'h41, 16'h0028, 1'b1}, {8'h41, 16'h0000, 1'b0}, {8'h47, 16'h00ff, 1'b0},
    {8'h47, 16'h0010, 1'b1}, {8'h50, 16'h0000, 1'b0}};

  pmblf_regs #(.PARALLEL_UNIT(1'b0)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp), .cal_lock(cal_lock),
    .ot_warn_level(ot_warn_level), .on_request(on_request), .fault_pin(fault_pin),
    .vout_target(vout_target), .ov_trip_level(ov_trip_level), .droop_slope(droop_slope),
    .input_turn_on_level_level(input_turn_on_level_level), .input_turn_off_level_level(input_turn_off_level_level), .oc_trip_level(oc_trip_level),
    .oc_warn_level(oc_warn_level), .ot_trip_level(ot_trip_level), .shutdown(shutdown),
    .restart(restart));

  pmblf_host host (.ref_clk(ref_clk), .cmd(cmd), .rsp(rsp));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic bad);
    host.xfer(1'b1, a, v, r);
    chk({13'h0, r.ack, r.bad_cmd, r.bad_data}, {15'h2, bad});
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    host.xfer(1'b0, a, 16'h0000, r);
    chk({13'h0, r.ack, r.bad_cmd, r.bad_data}, 16'h0004);
    chk(r.data, exp);
  endtask

  task automatic state_is(input logic [1:0] exp);
    repeat (4) @(negedge ref_clk);
    chk({14'h0, shutdown, restart}, {14'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    rst_n = 1'b0;
    cal_lock = 1'b0;
    on_request = 1'b0;
    fault_pin = 3'h0;
    ot_warn_level = 16'h0640;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    foreach (rst_tab[i]) begin
      shadow[rst_tab[i][23:16]] = rst_tab[i][15:0];
      rd(rst_tab[i][23:16], rst_tab[i][15:0]);
    end
    host.xfer(1'b0, 8'h22, 16'h0000, r);
    chk({r.bad_cmd, r.data[14:0]}, 16'h8000);
    host.xfer(1'b1, 8'h20, 16'h0055, r);
    chk({15'h0, r.bad_cmd}, 16'h0001);
    rd(8'h20, 16'h0014);
    $display("test reset and map done");
    foreach (steps[i]) begin
      {c, d, b} = steps[i];
      wr(c, d, b);
      if (!b) begin
        shadow[c] = (c inside {8'h41, 8'h47, 8'h50}) ?
          {8'h00, shadow[c][7:6], d[5:3], 3'h0} : d;
      end
      rd(c, shadow[c]);
    end
    chk(vout_target, 16'hd333);
    chk(ov_trip_level, 16'hffd7);
    chk(oc_trip_level, 16'h03c0);
    chk(oc_warn_level, 16'h031f);
    chk(droop_slope, 16'h01f4);
    chk(input_turn_on_level_level, 16'h02e0);
    chk(input_turn_off_level_level, 16'h02c0);
    chk(ot_trip_level, 16'h08c0);
    $display("test range checks done");
    wr(8'h21, 16'h8000, 1'b0);
    wr(8'h40, 16'hb000, 1'b0);
    // trip level follows the stored limit one cycle later
    @(negedge ref_clk);
    chk(ov_trip_level, 16'hb000);
    wr(8'h21, 16'h5000, 1'b0);
    repeat (2) @(negedge ref_clk);
    chk(ov_trip_level, 16'h8fd7);
    $display("test overvoltage ceiling done");
    cal_lock = 1'b1;
    wr(8'h23, 16'h0000, 1'b1);
    rd(8'h23, 16'hfc00);
    cal_lock = 1'b0;
    $display("test offset lock done");
    on_request = 1'b1;
    state_is(2'b00);
    fault_pin = 3'h1;
    state_is(2'b10);
    fault_pin = 3'h0;
    state_is(2'b10);
    on_request = 1'b0;
    state_is(2'b10);
    on_request = 1'b1;
    state_is(2'b00);
    fault_pin = 3'h2;
    state_is(2'b11);
    // a no-retry temperature fault during retry latches the unit off
    fault_pin = 3'h6;
    state_is(2'b10);
    fault_pin = 3'h0;
    on_request = 1'b0;
    state_is(2'b10);
    on_request = 1'b1;
    state_is(2'b00);
    fault_pin = 3'h2;
    state_is(2'b11);
    fault_pin = 3'h0;
    state_is(2'b00);
    $display("test fault handling done");
    complete_run();
  end
endmodule
